// ==== hdl/tlid_defs.svh ====
// Constants for the thermal limit and identity register bank.
// Assumes inclusion by name from any design file of the bank.
`ifndef TLID_DEFS_SVH
`define TLID_DEFS_SVH
`define TLID_CMD_LOCAL_LIMIT 8'h20
`define TLID_CMD_MAKER_ID 8'hFE
`define TLID_CMD_SILICON_REV 8'hFF
`define TLID_LOCAL_LIMIT_RESET 8'h46
// Arbitrary neutral identity values
`define TLID_MAKER_CODE 8'h5C
`define TLID_REVISION_CODE 8'h01
`define TLID_UNMAPPED_DATA 8'h00
`endif

// ==== hdl/tlid_pkg.sv ====
// Types for the thermal limit and identity register bank.
// Assumes no other package.
`default_nettype none
package tlid_pkg;
  typedef logic [7:0] tlid_byte_type;
  typedef logic signed [7:0] tlid_degree_type;
endpackage : tlid_pkg
`default_nettype wire

// ==== hdl/tlid_read_mux.sv ====
// Read data selection for the register bank.
// Assumes the command byte is stable while it is decoded.
`include "tlid_defs.svh"
`default_nettype none
module tlid_read_mux
(
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] limit_in,
  output logic [7:0] data_out,
  output logic hit_out
);
  always_comb
  begin
    hit_out = 1'b1;
    unique case (cmd_in)
      `TLID_CMD_LOCAL_LIMIT: data_out = limit_in;
      `TLID_CMD_MAKER_ID: data_out = `TLID_MAKER_CODE;
      `TLID_CMD_SILICON_REV: data_out = `TLID_REVISION_CODE;
      default:
      begin
        data_out = `TLID_UNMAPPED_DATA;
        hit_out = 1'b0;
      end
    endcase
  end
endmodule : tlid_read_mux
`default_nettype wire

// ==== hdl/tlid_regs.sv ====
// Local overtemperature limit and identity registers.
// Assumes a protocol engine presents single-cycle byte read and write strobes.
`include "tlid_defs.svh"
`default_nettype none
module tlid_regs
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] cmd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic rhit_out,
  output logic signed [7:0] local_overtemp_limit_out,
  output logic local_queue_purge_out
);
  tlid_pkg::tlid_byte_type limit_reg;
  tlid_pkg::tlid_byte_type rdata_reg;
  tlid_pkg::tlid_byte_type mux_data;
  logic rvalid_reg;
  logic rhit_reg;
  logic purge_reg;
  logic mux_hit;
  logic limit_wr;

  assign limit_wr = wr_in && (cmd_in == `TLID_CMD_LOCAL_LIMIT);

  tlid_read_mux u_mux
  (
    .cmd_in(cmd_in),
    .limit_in(limit_reg),
    .data_out(mux_data),
    .hit_out(mux_hit)
  );

  // Only the limit command stores data
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      limit_reg <= `TLID_LOCAL_LIMIT_RESET;
    else if (limit_wr)
      limit_reg <= wdata_in;
  end

  // One-cycle purge of the local fault queue
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      purge_reg <= 1'b0;
    else
      purge_reg <= limit_wr;
  end

  // Valid echoes the read strobe for one cycle
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rvalid_reg <= 1'b0;
    else
      rvalid_reg <= rd_in;
  end

  // Data and hit are captured on a read and held until the next
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rdata_reg <= 8'h00;
    else if (rd_in)
      rdata_reg <= mux_data;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rhit_reg <= 1'b0;
    else if (rd_in)
      rhit_reg <= mux_hit;
  end

  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign rhit_out = rhit_reg;
  assign local_overtemp_limit_out = tlid_pkg::tlid_degree_type'(limit_reg);
  assign local_queue_purge_out = purge_reg;

  sequence s_limit_write;
    wr_in && cmd_in == `TLID_CMD_LOCAL_LIMIT;
  endsequence

  sequence s_limit_read;
    rd_in && cmd_in == `TLID_CMD_LOCAL_LIMIT;
  endsequence

  sequence s_id_write;
    wr_in && (cmd_in == `TLID_CMD_MAKER_ID || cmd_in == `TLID_CMD_SILICON_REV);
  endsequence

  sequence s_no_write;
    !wr_in;
  endsequence

  property p_limit_reset;
    @(posedge mclk_in)
      srst_in |=> limit_reg == `TLID_LOCAL_LIMIT_RESET;
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("limit not at reset value");

  property p_reset_outputs;
    @(posedge mclk_in)
      srst_in |=> !rvalid_out && !rhit_out && rdata_out == 8'h00 && !local_queue_purge_out;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not cleared by reset");

  property p_limit_write;
    @(posedge mclk_in) disable iff (srst_in)
      limit_wr |=> limit_reg == $past(wdata_in);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("limit write lost");

  property p_limit_hold;
    @(posedge mclk_in) disable iff (srst_in)
      !limit_wr |=> $stable(limit_reg);
  endproperty
  a_limit_hold: assert property (p_limit_hold)
    else $error("limit changed without write");

  property p_limit_readback;
    @(posedge mclk_in) disable iff (srst_in)
      s_limit_write ##1 s_no_write ##1 s_limit_read |=> rdata_out == $past(wdata_in, 3) && rhit_out;
  endproperty
  a_limit_readback: assert property (p_limit_readback)
    else $error("limit readback wrong");

  property p_limit_read;
    @(posedge mclk_in) disable iff (srst_in)
      s_limit_read |=> rdata_out == $past(limit_reg) && rhit_out;
  endproperty
  a_limit_read: assert property (p_limit_read)
    else $error("limit read data wrong");

  property p_limit_signed;
    @(posedge mclk_in) disable iff (srst_in)
      (local_overtemp_limit_out < 8'sh00) == limit_reg[7];
  endproperty
  a_limit_signed: assert property (p_limit_signed)
    else $error("limit sign view wrong");

  property p_limit_degrees;
    @(posedge mclk_in) disable iff (srst_in)
      limit_wr |=> local_overtemp_limit_out == $signed($past(wdata_in));
  endproperty
  a_limit_degrees: assert property (p_limit_degrees)
    else $error("limit output value wrong");

  property p_purge_pulse;
    @(posedge mclk_in) disable iff (srst_in)
      s_limit_write |=> local_queue_purge_out;
  endproperty
  a_purge_pulse: assert property (p_purge_pulse)
    else $error("purge missing");

  property p_purge_cause;
    @(posedge mclk_in) disable iff (srst_in)
      local_queue_purge_out |-> $past(limit_wr);
  endproperty
  a_purge_cause: assert property (p_purge_cause)
    else $error("spurious purge");

  property p_purge_single;
    @(posedge mclk_in) disable iff (srst_in)
      local_queue_purge_out && !limit_wr |=> !local_queue_purge_out;
  endproperty
  a_purge_single: assert property (p_purge_single)
    else $error("purge longer than one cycle");

  property p_maker_read;
    @(posedge mclk_in) disable iff (srst_in)
      rd_in && cmd_in == `TLID_CMD_MAKER_ID |=> rvalid_out && rhit_out && rdata_out == `TLID_MAKER_CODE;
  endproperty
  a_maker_read: assert property (p_maker_read)
    else $error("maker code wrong");

  property p_rev_read;
    @(posedge mclk_in) disable iff (srst_in)
      rd_in && cmd_in == `TLID_CMD_SILICON_REV |=> rvalid_out && rhit_out && rdata_out == `TLID_REVISION_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision wrong");

  property p_id_write_inert;
    @(posedge mclk_in) disable iff (srst_in)
      wr_in && cmd_in != `TLID_CMD_LOCAL_LIMIT |=> $stable(limit_reg) && !local_queue_purge_out;
  endproperty
  a_id_write_inert: assert property (p_id_write_inert)
    else $error("ID write disturbed state");

  property p_id_then_read;
    @(posedge mclk_in) disable iff (srst_in)
      s_id_write ##1 s_no_write ##1 s_limit_read |=> rdata_out == $past(limit_reg, 3);
  endproperty
  a_id_then_read: assert property (p_id_then_read)
    else $error("limit moved after ID write");

  property p_rvalid_pulse;
    @(posedge mclk_in) disable iff (srst_in)
      rd_in |=> rvalid_out;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read valid missing");

  property p_rvalid_idle;
    @(posedge mclk_in) disable iff (srst_in)
      !rd_in |=> !rvalid_out;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle)
    else $error("read valid without read");

  property p_read_hold;
    @(posedge mclk_in) disable iff (srst_in)
      !rd_in |=> $stable(rdata_out) && $stable(rhit_out);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read result not held");

  property p_unmapped_read;
    @(posedge mclk_in) disable iff (srst_in)
      rd_in && cmd_in != `TLID_CMD_LOCAL_LIMIT && cmd_in != `TLID_CMD_MAKER_ID && cmd_in != `TLID_CMD_SILICON_REV
        |=> rdata_out == `TLID_UNMAPPED_DATA && !rhit_out;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not flagged");
endmodule : tlid_regs
`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench for the limit and identity bank.
// Assumes the host model drives every strobe.
`include "tlid_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic wr, rd, rv, hit, purge;
  logic [7:0] cmd, wd, rdata;
  logic signed [7:0] lim;
  logic [7:0] d;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] exp_lim = 8'h46;
  integer seed = 18834;
  always #2 mclk_in = ~mclk_in;
  tlid_host tlid_host_i (.mclk_in(mclk_in), .cmd_out(cmd), .wr_out(wr), .wdata_out(wd), .rd_out(rd));
  tlid_regs tlid_regs_i (.mclk_in(mclk_in), .srst_in(srst_in), .cmd_in(cmd), .wr_in(wr), .wdata_in(wd),
    .rd_in(rd), .rdata_out(rdata), .rvalid_out(rv), .rhit_out(hit), .local_overtemp_limit_out(lim),
    .local_queue_purge_out(purge));
  task chk(input string n, input logic [9:0] e, input logic [9:0] s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr_chk(input logic [7:0] c, input logic [7:0] v);
    tlid_host_i.xfer(1'b1, c, v);
    if (c == `TLID_CMD_LOCAL_LIMIT)
      exp_lim = v;
    #1 chk("write", {1'b0, c == `TLID_CMD_LOCAL_LIMIT, exp_lim}, {1'b0, purge, lim});
  endtask : wr_chk
  task rd_chk(input logic [7:0] c, input logic [7:0] e, input logic h);
    tlid_host_i.xfer(1'b0, c, 8'h00);
    #1 chk("read", {1'b1, h, e}, {rv, hit, rdata});
  endtask : rd_chk
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1 chk("reset", 10'h046, {2'b00, lim});
    rd_chk(`TLID_CMD_LOCAL_LIMIT, 8'h46, 1'b1);
    repeat (6)
    begin
      d = 8'($random(seed));
      wr_chk(`TLID_CMD_LOCAL_LIMIT, d);
      rd_chk(`TLID_CMD_LOCAL_LIMIT, exp_lim, 1'b1);
    end
    wr_chk(`TLID_CMD_LOCAL_LIMIT, 8'hC0);
    chk("sign", 10'h001, {9'h000, lim < 8'sh00});
    wr_chk(`TLID_CMD_MAKER_ID, 8'hA5);
    rd_chk(`TLID_CMD_LOCAL_LIMIT, exp_lim, 1'b1);
    wr_chk(`TLID_CMD_SILICON_REV, 8'h3C);
    rd_chk(`TLID_CMD_MAKER_ID, `TLID_MAKER_CODE, 1'b1);
    rd_chk(`TLID_CMD_SILICON_REV, `TLID_REVISION_CODE, 1'b1);
    rd_chk(8'h21, `TLID_UNMAPPED_DATA, 1'b0);
    stop_test();
  end
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// ==== verif/tlid_host.sv ====
// Host model issuing single byte writes and reads.
// Assumes the bank samples its strobes on the rising edge.
`default_nettype none
module tlid_host
(
  input wire logic mclk_in,
  output logic [7:0] cmd_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  task xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge mclk_in);
    cmd_out <= c;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~d;
  endtask : xfer
endmodule : tlid_host
`default_nettype wire
